// ---- core/prog_mem_pkg.sv ----
// Constants and types shared by the program memory protection block
`default_nettype none
package prog_mem_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 14;
  localparam int MEM_DEPTH = 4096;
  localparam logic [ADDR_W-1:0] USER_ID_BASE = 16'h8000;
  localparam logic [ADDR_W-1:0] USER_ID_LAST = 16'h8003;
  localparam logic [1:0] USER_ID_IDX_W = 2'h2;
  // Write protect field codes and the first address past the protected block for each code except WP_OFF
  localparam logic [1:0] WP_OFF = 2'h3;
  localparam logic [1:0] WP_QUARTER = 2'h2;
  localparam logic [1:0] WP_HALF = 2'h1;
  localparam logic [1:0] WP_ALL = 2'h0;
  localparam logic [ADDR_W-1:0] WP_QUARTER_END = 16'h0400;
  localparam logic [ADDR_W-1:0] WP_HALF_END = 16'h0800;
  localparam logic [ADDR_W-1:0] WP_ALL_END = 16'h1000;
  localparam logic [DATA_W-1:0] READ_BLANK = 14'h0000;
  localparam logic [DATA_W-1:0] USER_ID_RESET = 14'h3fff;
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_CPU,
    SRC_EXT
  } rd_src_t;
endpackage
`default_nettype wire

// ---- core/prog_mem_array.sv ----
// Synchronous single-port program memory with registered read data
`default_nettype none
module prog_mem_array #(
  parameter int DEPTH = 4096,
  parameter int AW = 12,
  parameter int DW = 14
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule
`default_nettype wire

// ---- core/program_memory_protection.sv ----
// Program memory access control: external code protect, self-write guard, user IDs
`default_nettype none
module program_memory_protection
  import prog_mem_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH,
  parameter int AW = 12
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic code_protect_n,
  input wire logic [1:0] write_protect_size,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [prog_mem_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic [prog_mem_pkg::DATA_W-1:0] cpu_wr_data,
  output logic [prog_mem_pkg::DATA_W-1:0] cpu_rd_data,
  output logic cpu_rd_valid,
  output logic cpu_wr_blocked,
  input wire logic ext_rd,
  input wire logic ext_wr,
  input wire logic [prog_mem_pkg::ADDR_W-1:0] ext_addr,
  input wire logic [prog_mem_pkg::DATA_W-1:0] ext_wr_data,
  output logic [prog_mem_pkg::DATA_W-1:0] ext_rd_data,
  output logic ext_rd_valid,
  output logic ext_refused
);
  import prog_mem_pkg::*;

  localparam int ID_WORDS = 2 ** USER_ID_IDX_W;

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] wp_end;
  logic cpu_is_id, ext_is_id, cpu_in_wp, cpu_wr_ok, ext_ok, cpu_sel;
  logic cpu_in_mem, ext_in_mem;
  logic mem_wr;
  logic [AW-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata, mem_rdata;
  logic [USER_ID_IDX_W-1:0] id_idx;
  logic [DATA_W-1:0] id_r [ID_WORDS];
  logic [DATA_W-1:0] id_nxt [ID_WORDS];
  rd_src_t src_r, src_nxt;
  logic from_id_r, from_id_nxt;
  logic [DATA_W-1:0] id_q_r, id_q_nxt;

  always_comb begin
    if (write_protect_size == WP_ALL) begin
      wp_end = WP_ALL_END;
    end else if (write_protect_size == WP_HALF) begin
      wp_end = WP_HALF_END;
    end else if (write_protect_size == WP_QUARTER) begin
      wp_end = WP_QUARTER_END;
    end else begin
      wp_end = '0;
    end
  end

  assign cpu_is_id = (cpu_addr >= USER_ID_BASE) && (cpu_addr <= USER_ID_LAST);
  assign ext_is_id = (ext_addr >= USER_ID_BASE) && (ext_addr <= USER_ID_LAST);
  assign cpu_in_mem = cpu_addr < ADDR_W'(DEPTH);
  assign ext_in_mem = ext_addr < ADDR_W'(DEPTH);
  // Boot block sits at the bottom of memory; code_protect_n plays no part here
  assign cpu_in_wp = cpu_in_mem && (cpu_addr < wp_end);
  assign cpu_wr_ok = cpu_wr && (cpu_is_id || (cpu_in_mem && !cpu_in_wp));
  assign cpu_wr_blocked = cpu_wr && cpu_in_wp;
  // External port is shut out entirely while protection is active
  assign ext_ok = code_protect_n;
  assign ext_refused = (ext_rd || ext_wr) && !code_protect_n;
  // CPU has priority; the programmer and a running program do not overlap in practice
  assign cpu_sel = cpu_rd || cpu_wr;

  always_comb begin
    mem_wr = 1'b0;
    mem_addr = AW'(ext_addr);
    mem_wdata = ext_wr_data;
    id_idx = ext_addr[USER_ID_IDX_W-1:0];
    if (cpu_sel) begin
      mem_addr = AW'(cpu_addr);
      mem_wdata = cpu_wr_data;
      id_idx = cpu_addr[USER_ID_IDX_W-1:0];
      mem_wr = cpu_wr_ok && !cpu_is_id;
    end else if (ext_wr && ext_ok && ext_in_mem) begin
      mem_wr = 1'b1;
    end
  end

  prog_mem_array #(
    .DEPTH(DEPTH),
    .AW(AW),
    .DW(DATA_W)
  ) u_mem (
    .sys_clk(sys_clk),
    .wr_en(mem_wr),
    .addr(mem_addr),
    .wr_data(mem_wdata),
    .rd_data(mem_rdata)
  );

  // ------------------------------------------------------------
  // User ID words and read tracking
  // ------------------------------------------------------------
  always_comb begin
    id_nxt = id_r;
    src_nxt = SRC_NONE;
    from_id_nxt = 1'b0;
    id_q_nxt = id_q_r;
    if (cpu_sel) begin
      if (cpu_wr_ok && cpu_is_id) begin
        id_nxt[id_idx] = cpu_wr_data;
      end
      if (cpu_rd) begin
        src_nxt = SRC_CPU;
        from_id_nxt = cpu_is_id;
        id_q_nxt = id_r[id_idx];
      end
    end else if (ext_ok) begin
      if (ext_wr && ext_is_id) begin
        id_nxt[id_idx] = ext_wr_data;
      end
      if (ext_rd) begin
        src_nxt = SRC_EXT;
        from_id_nxt = ext_is_id;
        id_q_nxt = id_r[id_idx];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ID_WORDS; i++) begin
        id_r[i] <= USER_ID_RESET;
      end
      src_r <= SRC_NONE;
      from_id_r <= 1'b0;
      id_q_r <= READ_BLANK;
    end else begin
      id_r <= id_nxt;
      src_r <= src_nxt;
      from_id_r <= from_id_nxt;
      id_q_r <= id_q_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read return
  // ------------------------------------------------------------
  logic ext_rd_blank_r, ext_rd_blank_nxt;
  logic [DATA_W-1:0] word;

  assign ext_rd_blank_nxt = !cpu_sel && ext_rd && !ext_ok;
  assign word = from_id_r ? id_q_r : mem_rdata;
  assign cpu_rd_valid = (src_r == SRC_CPU);
  assign cpu_rd_data = (src_r == SRC_CPU) ? word : READ_BLANK;
  assign ext_rd_valid = (src_r == SRC_EXT) || ext_rd_blank_r;
  // A refused read with no CPU access in its cycle still answers, but with every bit cleared
  assign ext_rd_data = (src_r == SRC_EXT) ? word : READ_BLANK;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ext_rd_blank_r <= 1'b0;
    end else begin
      ext_rd_blank_r <= ext_rd_blank_nxt;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_ext_wr_blocked;
    @(posedge sys_clk) disable iff (reset)
      (!code_protect_n && ext_wr) |-> !mem_wr || cpu_sel;
  endproperty
  a_ext_wr_blocked: assert property (p_ext_wr_blocked)
    else $error("external write reached memory under code protection");

  property p_ext_rd_zero;
    @(posedge sys_clk) disable iff (reset)
      (!cpu_sel && ext_rd && !code_protect_n) |=> (ext_rd_valid && ext_rd_data == READ_BLANK);
  endproperty
  a_ext_rd_zero: assert property (p_ext_rd_zero)
    else $error("protected external read did not return zero");

  property p_cpu_rd_served;
    @(posedge sys_clk) disable iff (reset)
      cpu_rd |=> cpu_rd_valid;
  endproperty
  a_cpu_rd_served: assert property (p_cpu_rd_served)
    else $error("cpu read not answered");

  property p_wp_blocks;
    @(posedge sys_clk) disable iff (reset)
      (cpu_wr && cpu_in_mem && cpu_addr < wp_end) |-> !mem_wr && cpu_wr_blocked;
  endproperty
  a_wp_blocks: assert property (p_wp_blocks)
    else $error("write into protected block not ignored");

  property p_wp_allows;
    @(posedge sys_clk) disable iff (reset)
      (cpu_wr && cpu_in_mem && cpu_addr >= wp_end) |-> mem_wr;
  endproperty
  a_wp_allows: assert property (p_wp_allows)
    else $error("writable location refused a cpu write");

  property p_id_write;
    @(posedge sys_clk) disable iff (reset)
      (cpu_wr && cpu_is_id) |=> id_r[$past(id_idx)] == $past(cpu_wr_data);
  endproperty
  a_id_write: assert property (p_id_write)
    else $error("user id write lost");

  property p_size_off;
    @(posedge sys_clk) disable iff (reset)
      (write_protect_size == WP_OFF && cpu_wr && cpu_in_mem) |-> mem_wr && !cpu_wr_blocked;
  endproperty
  a_size_off: assert property (p_size_off)
    else $error("protection active with field off");

  property p_ext_refused_flag;
    @(posedge sys_clk) disable iff (reset)
      ((ext_rd || ext_wr) && code_protect_n) |->
        !ext_refused && (!ext_wr || cpu_sel || !ext_in_mem || mem_wr);
  endproperty
  a_ext_refused_flag: assert property (p_ext_refused_flag)
    else $error("external access refused while unprotected");

  c_ext_blank: cover property (@(posedge sys_clk) disable iff (reset)
    ext_rd && !code_protect_n && !cpu_sel);
  c_wp_hit: cover property (@(posedge sys_clk) disable iff (reset) cpu_wr_blocked);
  c_id_rw: cover property (@(posedge sys_clk) disable iff (reset) cpu_wr && cpu_is_id ##1 cpu_rd);
endmodule
`default_nettype wire

// ---- verif/prog_programmer_model.sv ----
// Behavioural external device programmer on the programming port
`default_nettype none
module prog_programmer_model
  import prog_mem_pkg::*;
(
  input wire logic sys_clk,
  input wire logic req_go,
  input wire logic req_wr,
  input wire logic [prog_mem_pkg::ADDR_W-1:0] req_addr,
  input wire logic [prog_mem_pkg::DATA_W-1:0] req_data,
  output logic ext_rd,
  output logic ext_wr,
  output logic [prog_mem_pkg::ADDR_W-1:0] ext_addr,
  output logic [prog_mem_pkg::DATA_W-1:0] ext_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [ADDR_W-1:0] addr_q = 16'h0000;
  logic [DATA_W-1:0] data_q = 14'h0000;
  // Idle address and data lines flip every cycle so a stale address never passes for a live one
  always @(posedge sys_clk) begin
    rd_q <= req_go && !req_wr;
    wr_q <= req_go && req_wr;
    addr_q <= req_go ? req_addr : ~addr_q;
    data_q <= req_go ? req_data : ~data_q;
  end
  assign ext_rd = rd_q;
  assign ext_wr = wr_q;
  assign ext_addr = addr_q;
  assign ext_wr_data = data_q;
endmodule
`default_nettype wire

// ---- verif/tb_program_memory_protection.sv ----
// Self-checking bench for program memory access control
`default_nettype none
module tb_program_memory_protection;
  timeunit 1ns;
  timeprecision 1ns;
  import prog_mem_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, code_protect_n = 1'b1, cpu_rd = 1'b0, cpu_wr = 1'b0;
  logic [1:0] write_protect_size = WP_OFF;
  logic [ADDR_W-1:0] cpu_addr = 16'h0000, ext_addr, req_addr = 16'h0000;
  logic [DATA_W-1:0] cpu_wr_data = 14'h0000, ext_wr_data, req_data = 14'h0000;
  logic [DATA_W-1:0] cpu_rd_data, ext_rd_data;
  logic cpu_rd_valid, cpu_wr_blocked, ext_rd, ext_wr, ext_rd_valid, ext_refused;
  logic req_go = 1'b0, req_wr = 1'b0;
  logic [DATA_W-1:0] mdl [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] addrs [10] = '{16'h0000, 16'h03ff, 16'h0400, 16'h07ff, 16'h0800,
                                     16'h0fff, 16'h8000, 16'h8001, 16'h8002, 16'h8003};
  int err_total = 0, samples_checked = 0, cycles = 0, seed = 95954;
  logic [31:0] r;
  program_memory_protection dut (.sys_clk(sys_clk), .reset(reset),
    .code_protect_n(code_protect_n), .write_protect_size(write_protect_size),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wr_data(cpu_wr_data),
    .cpu_rd_data(cpu_rd_data), .cpu_rd_valid(cpu_rd_valid), .cpu_wr_blocked(cpu_wr_blocked),
    .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wr_data(ext_wr_data),
    .ext_rd_data(ext_rd_data), .ext_rd_valid(ext_rd_valid), .ext_refused(ext_refused));
  prog_programmer_model prog (.sys_clk(sys_clk), .req_go(req_go), .req_wr(req_wr),
    .req_addr(req_addr), .req_data(req_data), .ext_rd(ext_rd), .ext_wr(ext_wr),
    .ext_addr(ext_addr), .ext_wr_data(ext_wr_data));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Expectations and checking
  // ----------------------------------------
  function automatic logic shielded(input logic [1:0] wp, input logic [ADDR_W-1:0] a);
    case (wp)
      WP_QUARTER: shielded = a < WP_QUARTER_END;
      WP_HALF: shielded = a < WP_HALF_END;
      WP_ALL: shielded = a < WP_ALL_END;
      default: shielded = 1'b0;
    endcase
  endfunction
  task automatic check(input string name, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One access on either port; settings change at the same edge as the request
  task automatic access(input logic ext, input logic wr, input logic cp, input logic [1:0] wp,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic blk;
    blk = shielded(wp, a);
    @(posedge sys_clk);
    code_protect_n <= cp;
    write_protect_size <= wp;
    if (ext) begin
      {req_go, req_wr, req_addr, req_data} <= {1'b1, wr, a, d};
      @(posedge sys_clk);
      req_go <= 1'b0;
    end else begin
      {cpu_rd, cpu_wr, cpu_addr, cpu_wr_data} <= {!wr, wr, a, d};
    end
    @(negedge sys_clk);
    if (ext) check("ext_refused", ext_refused, !cp);
    else if (wr) check("cpu_wr_blocked", cpu_wr_blocked, blk);
    @(posedge sys_clk);
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b0;
    @(negedge sys_clk);
    if (!wr && ext) begin
      check("ext_rd_valid", ext_rd_valid, 1'b1);
      if (!cp) check("ext_rd_data", ext_rd_data, READ_BLANK);
      else if (mdl.exists(a)) check("ext_rd_data", ext_rd_data, mdl[a]);
    end else if (!wr) begin
      check("cpu_rd_valid", cpu_rd_valid, 1'b1);
      if (mdl.exists(a)) check("cpu_rd_data", cpu_rd_data, mdl[a]);
    end else if (ext ? cp : !blk) mdl[a] = d;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total++;
      test_done();
    end
  end
  // ----------------------------------------
  // Main sequence: ID reset, fill, corners, then random traffic
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 6; i < 10; i++) mdl[addrs[i]] = USER_ID_RESET;
    for (int i = 6; i < 10; i++) access(1'b0, 1'b0, 1'b1, WP_OFF, addrs[i], 14'h0000);
    for (int i = 0; i < 10; i++) access(1'b0, 1'b1, 1'b1, WP_OFF, addrs[i], 14'h0100 + i);
    access(1'b1, 1'b0, 1'b0, WP_OFF, 16'h0000, 14'h0000);
    access(1'b1, 1'b1, 1'b0, WP_OFF, 16'h0000, 14'h2aaa);
    access(1'b0, 1'b0, 1'b0, WP_OFF, 16'h0000, 14'h0000);
    for (int i = 0; i < 4; i++) begin
      access(1'b0, 1'b1, i[0], i[1:0], 16'h03ff, 14'h1555);
      access(1'b0, 1'b1, i[0], i[1:0], 16'h0400, 14'h0aaa);
      access(1'b0, 1'b0, 1'b1, i[1:0], 16'h03ff, 14'h0000);
      access(1'b0, 1'b0, 1'b1, i[1:0], 16'h0400, 14'h0000);
    end
    repeat (300) begin
      r = $random(seed);
      access(r[3], r[4], r[0], r[2:1], addrs[r[8:5] % 10], r[22:9]);
    end
    test_done();
  end
endmodule
`default_nettype wire
